// ==== core/ubf_regs.vh ====
// Purpose : register map of one serial unit
// Assumes : byte address is four times the index
// Notes   : definitions only
`ifndef UBF_REGS_VH
`define UBF_REGS_VH

// ------------------------------------------------------------------
// register indices
// ------------------------------------------------------------------
`define UBF_IDX_CSR      10'h086
`define UBF_IDX_UCR      10'h0C4
`define UBF_IDX_DBUF     10'h0C1
`define UBF_IDX_BAUD     10'h0C2
`define UBF_IDX_IRQ      10'h0C3
`define UBF_IDX_GCR      10'h0C5

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define UBF_CSR_MODE     7
`define UBF_CSR_RE       6
`define UBF_CSR_SLAVE    5
`define UBF_CSR_FE       4
`define UBF_CSR_ERR      3
`define UBF_CSR_RXB      2
`define UBF_CSR_TXB      1
`define UBF_CSR_ACT      0
`define UBF_UCR_FLUSH    7
`define UBF_GCR_CPOL     7
`define UBF_GCR_SAMPLE_PHASE     6
`define UBF_GCR_ORDER    5
`define UBF_IRQ_RXIE     0
`define UBF_IRQ_TXIE     1
`define UBF_IRQ_RXF      2
`define UBF_IRQ_TXF      3

// ------------------------------------------------------------------
// reset values and rate constants
// ------------------------------------------------------------------
`define UBF_RST_BYTE     8'h00
`define UBF_RATE_BASE    9'h100
`define UBF_ACC_HALF     28'h800_0000
`define UBF_UART_LAST    5'h09
`define UBF_SPI_LAST     5'h0F

`endif

// ==== core/ubf_unit.v ====
// Purpose : one serial unit with rate generator and flush
// Assumes : 100 MHz clock, APB access
// Notes   : half duplex in async mode, master shifts both ways; slave transfers never start
`timescale 1ns/1ps
`include "ubf_regs.vh"

// How it works
// R1 - rate is (256+mant) * 2^exp / 2^28 * clock
// R2 - one generator serves async and master clock
// R3 - async mode reaches clock/16 at exp 16
// R4 - receiving master reaches clock/8 at exp 17
// R5 - transmit-only master reaches clock/2 at exp 19
// R6 - slave clock at most clock/8, master obeys
// R7 - software sets rate before any transfer
// R8 - 26 MHz standard rates from table settings
// R9 - 24 MHz standard rates from table settings
// R10 - flush stops operation, clears buffers, idles
// R11 - software waits a bit after flush
// R12 - done flags request irq only when enabled
// R13 - dma triggers follow the same done events
// R14 - dma reaches data buffer like the cpu
// R15 - software avoids dma with sample phase one
// R16 - six registers per unit instance
// R17 - bit7 selects async, bit5 selects slave
// R18 - bit6 is the receiver enable
// R19 - bit4 framing error, write zero only
// R20 - bad stop bit sets, status read clears
module ubf_unit (
    // clock, reset and freeze
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire        pready_o,
    output wire        pslverr_o,
    // serial pins
    input  wire        rxd_i,
    output wire        txd_o,
    output wire        sck_o,
    output wire        mosi_o,
    input  wire        miso_i,
    // events
    output wire        rx_irq_o,
    output wire        tx_irq_o,
    output wire        rx_dma_trigger_o,
    output wire        tx_dma_trigger_o
);

    // ------------------------------------------------------------------
    // engine states
    // ------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_UTX  = 2'b01;
    localparam [1:0] ST_URX  = 2'b10;
    localparam [1:0] ST_SPI  = 2'b11;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // step (256 + mant) << exp, one more for half periods
    function [28:0] rate_inc;
        input [7:0] mant;
        input [4:0] expo;
        input       dbl;
        reg   [37:0] wide;
        begin
            wide = {29'd0, `UBF_RATE_BASE | {1'b0, mant}} << ({1'b0, expo} + {5'd0, dbl});
            rate_inc = wide[28:0];
        end
    endfunction

    // shift one bit in, by bit order
    function [7:0] spi_shift;
        input [7:0] cur;
        input       bit_in;
        input       msb_first;
        begin
            spi_shift = msb_first ? {cur[6:0], bit_in} : {bit_in, cur[7:1]};
        end
    endfunction

    // ------------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------------
    reg        mode_q;          // 1 async, 0 synchronous
    reg        rx_enable_bit_q; // receiver enable
    reg        slave_q;         // synchronous slave select
    reg        framing_error_q; // bad stop bit seen
    reg        err_q;           // parity status, never set here
    reg        rxb_q;           // received byte ready
    reg        txb_q;           // last byte shifted out
    reg  [6:0] ucr_q;           // async control, flush not stored
    reg        cpol_q;          // idle clock level
    reg        sample_phase_q;  // clock phase
    reg        order_q;         // 1 msb first
    reg  [4:0] baud_e_q;        // rate exponent
    reg  [7:0] baud_m_q;        // rate mantissa
    reg        rx_irq_enable_q; // receive irq enable
    reg        tx_irq_enable_q; // transmit irq enable
    reg        rx_done_flag_q;  // receive complete flag
    reg        tx_done_flag_q;  // transmit start flag, holding byte taken
    reg  [7:0] hold_q;          // transmit holding byte
    reg        hold_v_q;        // holding byte valid
    reg  [7:0] rx_buf_q;        // receive data buffer
    reg  [1:0] state_q;         // engine state
    reg [27:0] acc_q;           // rate accumulator
    reg  [4:0] cnt_q;           // bit or edge counter
    reg  [8:0] sh_q;            // shift register
    reg        txd_q;           // async line out
    reg        sck_q;           // master clock out
    reg        mosi_q;          // master data out
    reg        rxd_m_q;         // rxd sync stage 1
    reg        rxd_s_q;         // rxd sync stage 2
    reg        rxd_p_q;         // rxd previous, for start edge
    reg        miso_m_q;        // miso sync stage 1
    reg        miso_s_q;        // miso sync stage 2
    reg [31:0] prdata_q;        // read data
    reg        rx_pulse_q;      // receive dma trigger
    reg        tx_pulse_q;      // transmit dma trigger
    reg [31:0] rd_mux;          // read mux value

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire       acc_en   = psel_i & penable_i & ce_i;
    wire       wr_en    = acc_en & pwrite_i;
    wire       rd_en    = acc_en & ~pwrite_i;
    wire       hit_csr  = (paddr_i[11:2] == `UBF_IDX_CSR);
    wire       hit_ucr  = (paddr_i[11:2] == `UBF_IDX_UCR);
    wire       hit_dbuf = (paddr_i[11:2] == `UBF_IDX_DBUF);
    wire       hit_baud = (paddr_i[11:2] == `UBF_IDX_BAUD);
    wire       hit_irq  = (paddr_i[11:2] == `UBF_IDX_IRQ);
    wire       hit_gcr  = (paddr_i[11:2] == `UBF_IDX_GCR);
    wire       hit_any  = hit_csr | hit_ucr | hit_dbuf | hit_baud | hit_irq | hit_gcr;
    wire [7:0] wb       = pwdata_i[7:0];

    assign pready_o  = ce_i;
    assign pslverr_o = psel_i & penable_i & ~hit_any;
    assign prdata_o  = prdata_q;

    // flush is a write-one strobe
    wire flush = wr_en & hit_ucr & wb[`UBF_UCR_FLUSH];

    // ------------------------------------------------------------------
    // rate generator and engine events
    // ------------------------------------------------------------------
    // one accumulator for bits and half sck periods
    wire [28:0] inc  = rate_inc(baud_m_q, baud_e_q, state_q == ST_SPI); // see R1, see R2
    wire [28:0] sum  = {1'b0, acc_q} + inc;
    wire        tick = sum[28];

    // holding byte enters the engine, never as slave
    wire start_tx  = hold_v_q & (state_q == ST_IDLE) & ~flush & (mode_q | ~slave_q); // see R6
    // start edge while receiving
    wire start_rx  = (state_q == ST_IDLE) & ~hold_v_q & ~flush & mode_q & rx_enable_bit_q
                     & rxd_p_q & ~rxd_s_q;
    wire utx_end   = (state_q == ST_UTX) & tick & (cnt_q == `UBF_UART_LAST);
    wire urx_stop  = (state_q == ST_URX) & tick & (cnt_q == `UBF_UART_LAST);
    wire rx_ok     = urx_stop & rxd_s_q;
    wire fe_evt    = urx_stop & ~rxd_s_q;                          // see R20
    wire spi_end   = (state_q == ST_SPI) & tick & (cnt_q == `UBF_SPI_LAST);
    wire spi_samp  = (cnt_q[0] == sample_phase_q);
    wire [7:0] spi_next = spi_shift(sh_q[7:0], miso_s_q, order_q);
    wire rx_evt    = rx_ok | spi_end;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // two flops before any logic
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rxd_m_q  <= 1'b1;
            rxd_s_q  <= 1'b1;
            rxd_p_q  <= 1'b1;
            miso_m_q <= 1'b0;
            miso_s_q <= 1'b0;
        end else if (ce_i) begin
            rxd_m_q  <= rxd_i;
            rxd_s_q  <= rxd_m_q;
            rxd_p_q  <= rxd_s_q;
            miso_m_q <= miso_i;
            miso_s_q <= miso_m_q;
        end
    end

    // ------------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------------
    // rate limits follow from the step
    // see R3, see R4, see R5, see R8, see R9
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q  <= ST_IDLE;
            acc_q    <= 28'h000_0000;
            cnt_q    <= 5'h00;
            sh_q     <= 9'h000;
            txd_q    <= 1'b1;
            sck_q    <= 1'b0;
            mosi_q   <= 1'b0;
            rx_buf_q <= `UBF_RST_BYTE;
        end else if (ce_i) begin
            acc_q <= sum[27:0];
            if (flush) begin
                // abort, drop data, line idle
                state_q  <= ST_IDLE;                               // see R10
                sh_q     <= 9'h000;
                rx_buf_q <= `UBF_RST_BYTE;
                txd_q    <= 1'b1;
                sck_q    <= cpol_q;
                cnt_q    <= 5'h00;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        sck_q <= cpol_q;
                        cnt_q <= 5'h00;
                        if (start_tx && mode_q) begin
                            // start bit now, data then stop bit
                            state_q <= ST_UTX;
                            acc_q   <= 28'h000_0000;
                            txd_q   <= 1'b0;
                            sh_q    <= {1'b1, hold_q};
                        end else if (start_tx) begin
                            // master, first bit early
                            state_q <= ST_SPI;
                            acc_q   <= 28'h000_0000;
                            sh_q    <= {1'b0, hold_q};
                            mosi_q  <= order_q ? hold_q[7] : hold_q[0];
                        end else if (start_rx) begin
                            // sample in the middle of each bit
                            state_q <= ST_URX;
                            acc_q   <= `UBF_ACC_HALF;
                        end
                    end
                    ST_UTX: begin
                        if (tick) begin
                            if (cnt_q == `UBF_UART_LAST) begin
                                state_q <= ST_IDLE;
                            end else begin
                                txd_q <= sh_q[0];
                                sh_q  <= {1'b0, sh_q[8:1]};
                                cnt_q <= cnt_q + 5'h01;
                            end
                        end
                    end
                    ST_URX: begin
                        if (tick) begin
                            if (cnt_q == 5'h00 && rxd_s_q) begin
                                // glitch, no start bit
                                state_q <= ST_IDLE;
                            end else if (cnt_q == `UBF_UART_LAST) begin
                                state_q <= ST_IDLE;
                                if (rxd_s_q) begin
                                    rx_buf_q <= sh_q[7:0];
                                end
                            end else begin
                                if (cnt_q != 5'h00) begin
                                    sh_q <= {1'b0, rxd_s_q, sh_q[7:1]};
                                end
                                cnt_q <= cnt_q + 5'h01;
                            end
                        end
                    end
                    ST_SPI: begin
                        if (tick) begin
                            sck_q <= ~sck_q;
                            cnt_q <= cnt_q + 5'h01;
                            if (spi_samp) begin
                                sh_q <= {1'b0, spi_next};
                            end else begin
                                mosi_q <= order_q ? sh_q[7] : sh_q[0];
                            end
                            if (cnt_q == `UBF_SPI_LAST) begin
                                state_q  <= ST_IDLE;
                                rx_buf_q <= spi_samp ? spi_next : sh_q[7:0];
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // control registers written by software
    // ------------------------------------------------------------------
    // software writable fields
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q          <= 1'b0;
            rx_enable_bit_q <= 1'b0;
            slave_q         <= 1'b0;
            ucr_q           <= 7'h00;
            cpol_q          <= 1'b0;
            sample_phase_q  <= 1'b0;
            order_q         <= 1'b0;
            baud_e_q        <= 5'h00;
            baud_m_q        <= `UBF_RST_BYTE;
            rx_irq_enable_q <= 1'b0;
            tx_irq_enable_q <= 1'b0;
        end else if (ce_i && wr_en) begin
            if (hit_csr) begin
                mode_q          <= wb[`UBF_CSR_MODE];              // see R17
                rx_enable_bit_q <= wb[`UBF_CSR_RE];                // see R18
                slave_q         <= wb[`UBF_CSR_SLAVE];             // see R17
            end
            if (hit_ucr) begin
                ucr_q <= wb[6:0];
            end
            if (hit_gcr) begin
                cpol_q         <= wb[`UBF_GCR_CPOL];
                sample_phase_q <= wb[`UBF_GCR_SAMPLE_PHASE];
                order_q        <= wb[`UBF_GCR_ORDER];
                baud_e_q       <= wb[4:0];                         // see R1
            end
            if (hit_baud) begin
                baud_m_q <= wb;                                    // see R1
            end
            if (hit_irq) begin
                rx_irq_enable_q <= wb[`UBF_IRQ_RXIE];
                tx_irq_enable_q <= wb[`UBF_IRQ_TXIE];
            end
        end
    end

    // ------------------------------------------------------------------
    // status flags: clears first, sets win
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            framing_error_q <= 1'b0;
            err_q           <= 1'b0;
            rxb_q           <= 1'b0;
            txb_q           <= 1'b0;
            rx_done_flag_q  <= 1'b0;
            tx_done_flag_q  <= 1'b0;
            hold_q          <= `UBF_RST_BYTE;
            hold_v_q        <= 1'b0;
            rx_pulse_q      <= 1'b0;
            tx_pulse_q      <= 1'b0;
        end else if (ce_i) begin
            // status read clears error bits
            if (rd_en && hit_csr) begin
                framing_error_q <= 1'b0;                           // see R20
                err_q           <= 1'b0;
            end
            // error and byte bits accept only a zero
            if (wr_en && hit_csr) begin
                if (!wb[`UBF_CSR_FE])  framing_error_q <= 1'b0;    // see R19
                if (!wb[`UBF_CSR_ERR]) err_q           <= 1'b0;
                if (!wb[`UBF_CSR_RXB]) rxb_q           <= 1'b0;
                if (!wb[`UBF_CSR_TXB]) txb_q           <= 1'b0;
            end
            if (wr_en && hit_irq) begin
                if (!wb[`UBF_IRQ_RXF]) rx_done_flag_q <= 1'b0;
                if (!wb[`UBF_IRQ_TXF]) tx_done_flag_q <= 1'b0;
            end
            // buffer read consumes the byte
            if (rd_en && hit_dbuf) begin
                rxb_q <= 1'b0;                                     // see R14
            end
            // buffer write fills the holding byte
            if (wr_en && hit_dbuf) begin
                hold_q   <= wb;                                    // see R14
                hold_v_q <= 1'b1;
            end else if (start_tx) begin
                hold_v_q <= 1'b0;
            end
            if (flush) begin
                hold_v_q <= 1'b0;                                  // see R10
                rxb_q    <= 1'b0;
            end
            // hardware events
            if (fe_evt) framing_error_q <= 1'b1;                   // see R20
            if (rx_evt) begin
                rxb_q          <= 1'b1;
                rx_done_flag_q <= 1'b1;                            // see R12
            end
            if (utx_end || spi_end) txb_q <= 1'b1;
            if (start_tx) tx_done_flag_q <= 1'b1;                  // see R12
            rx_pulse_q <= rx_evt;                                  // see R13
            tx_pulse_q <= start_tx;                                // see R13
        end
    end

    // ------------------------------------------------------------------
    // read data, captured in the setup cycle
    // ------------------------------------------------------------------
    always @* begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit_csr:  rd_mux[7:0] = {mode_q, rx_enable_bit_q, slave_q, framing_error_q,
                                     err_q, rxb_q, txb_q, state_q != ST_IDLE};  // see R16
            hit_ucr:  rd_mux[7:0] = {1'b0, ucr_q};
            hit_gcr:  rd_mux[7:0] = {cpol_q, sample_phase_q, order_q, baud_e_q};
            hit_dbuf: rd_mux[7:0] = rx_buf_q;
            hit_baud: rd_mux[7:0] = baud_m_q;
            hit_irq:  rd_mux[7:0] = {4'h0, tx_done_flag_q, rx_done_flag_q,
                                     tx_irq_enable_q, rx_irq_enable_q};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (ce_i && psel_i && !penable_i && !pwrite_i) begin
            prdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign txd_o            = txd_q;
    assign sck_o            = sck_q;
    assign mosi_o           = mosi_q;
    assign rx_irq_o         = rx_done_flag_q & rx_irq_enable_q;    // see R12
    assign tx_irq_o         = tx_done_flag_q & tx_irq_enable_q;    // see R12
    assign rx_dma_trigger_o = rx_pulse_q;
    assign tx_dma_trigger_o = tx_pulse_q;

endmodule

// ==== verif/testbench.sv ====
// Purpose: self checking bench of one serial unit
// Assumes: zero wait apb slave, 100 MHz clock
// Notes: rates picked so bit times are whole clocks
`timescale 1ns/1ps
`include "ubf_regs.vh"
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin bad_count++; \
    $display("ERROR %0t: got %h exp %h", $time, g, x); end end
module testbench;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, send = 1'b0, bad = 1'b0, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0]  r, sbyte = 8'h3C;
    wire  [31:0] prdata;
    wire         pready, pslverr, rxd, txd, sck, mosi, miso, rx_irq, tx_irq, rx_trg, tx_trg;
    int          bad_count = 0, n_checks = 0, cyc = 0, rx_cnt = 0, tx_cnt = 0, i, n;
    typedef struct packed { logic [9:0] idx; logic [7:0] wd; logic [7:0] rd; } ubf_row_t;
    ubf_row_t    rows [8];
    always #5 clk = ~clk;
    ubf_unit u_ubf_unit (.clk_sys_i(clk), .rst_n_i(rst_n), .ce_i(ce), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rxd_i(rxd), .txd_o(txd),
        .sck_o(sck), .mosi_o(mosi), .miso_i(miso), .rx_irq_o(rx_irq), .tx_irq_o(tx_irq),
        .rx_dma_trigger_o(rx_trg), .tx_dma_trigger_o(tx_trg));
    ubf_peer #(.BIT_CLKS(16)) u_ubf_peer (.clk_i(clk), .send_i(send), .bad_stop_i(bad),
        .mosi_i(mosi), .byte_i(sbyte), .rxd_o(rxd), .miso_o(miso));
    // event counters and hang limit
    always @(posedge clk) begin
        cyc++;
        if (rx_trg) rx_cnt++;
        if (tx_trg) tx_cnt++;
        if (cyc == 10000) begin bad_count++; wrap_up(); end
    end
    task automatic wrap_up();
        if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // one apb transfer, waits for ready
    task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h00_0000, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata[7:0]; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic rdc(input logic [9:0] i, input logic [7:0] x); apb(1'b0, i, 8'h00);
        `CHK(r, x) endtask
    task automatic sck_per(input int x);
        for (n = 0; n < 99 && sck !== 1'b1; n++) @(posedge clk);
        n = 0;
        do begin @(posedge clk); n++; end while (sck !== 1'b0 && n < 99);
        do begin @(posedge clk); n++; end while (sck !== 1'b1 && n < 99);
        `CHK(n, x) endtask
    initial begin
        rows = '{'{`UBF_IDX_GCR, 8'hB0, 8'hB0}, '{`UBF_IDX_BAUD, 8'hA5, 8'hA5},
            '{`UBF_IDX_CSR, 8'h60, 8'h60}, '{`UBF_IDX_DBUF, 8'h5A, 8'h00},
            '{`UBF_IDX_UCR, 8'h7F, 8'h7F}, '{`UBF_IDX_UCR, 8'h80, 8'h00},
            '{`UBF_IDX_IRQ, 8'h03, 8'h03}, '{`UBF_IDX_IRQ, 8'h0C, 8'h00}};
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        ce <= 1'b1;
        foreach (rows[k]) rdc(rows[k].idx, 8'h00);
        foreach (rows[k]) begin apb(1'b1, rows[k].idx, rows[k].wd); repeat (16) @(posedge clk);
            rdc(rows[k].idx, rows[k].rd); end
        apb(1'b1, 10'h000, 8'hFF); `CHK(e, 1'b1)
        rdc(10'h000, 8'h00); `CHK(e, 1'b1)
        // async transmit at clock/16
        apb(1'b1, `UBF_IDX_GCR, 8'h10); apb(1'b1, `UBF_IDX_BAUD, 8'h00);
        apb(1'b1, `UBF_IDX_IRQ, 8'h02); apb(1'b1, `UBF_IDX_CSR, 8'h80);
        apb(1'b1, `UBF_IDX_DBUF, 8'hA5);
        for (n = 0; n < 40 && txd !== 1'b0; n++) @(posedge clk);
        repeat (8) @(posedge clk);
        for (i = 0; i < 10; i++) begin `CHK(txd, 10'h34A >> i & 1'b1) repeat (16) @(posedge clk); end
        `CHK(tx_cnt, 1) `CHK(tx_irq, 1'b1)
        rdc(`UBF_IDX_CSR, 8'h82);
        // async receive, flag masked then unmasked
        apb(1'b1, `UBF_IDX_IRQ, 8'h00); apb(1'b1, `UBF_IDX_CSR, 8'hC0);
        send <= 1'b1; @(posedge clk); send <= 1'b0;
        for (n = 0; n < 400 && rx_cnt != 1; n++) @(posedge clk);
        `CHK(rx_irq, 1'b0)
        apb(1'b1, `UBF_IDX_IRQ, 8'h05); @(posedge clk); `CHK(rx_irq, 1'b1)
        rdc(`UBF_IDX_CSR, 8'hC4); rdc(`UBF_IDX_DBUF, 8'h3C); rdc(`UBF_IDX_CSR, 8'hC0);
        bad <= 1'b1; send <= 1'b1; @(posedge clk); send <= 1'b0;
        repeat (220) @(posedge clk);
        rdc(`UBF_IDX_CSR, 8'hD0); rdc(`UBF_IDX_CSR, 8'hC0); `CHK(rx_cnt, 1)
        // flush in mid frame
        apb(1'b1, `UBF_IDX_CSR, 8'h80); apb(1'b1, `UBF_IDX_DBUF, 8'h00);
        repeat (40) @(posedge clk);
        apb(1'b1, `UBF_IDX_UCR, 8'h80); @(posedge clk); `CHK(txd, 1'b1)
        repeat (16) @(posedge clk); rdc(`UBF_IDX_CSR, 8'h80);
        // master clock from the same generator
        apb(1'b1, `UBF_IDX_CSR, 8'h00); apb(1'b1, `UBF_IDX_GCR, 8'h11);
        apb(1'b1, `UBF_IDX_DBUF, 8'h96); sck_per(8);
        for (n = 0; n < 400 && rx_cnt != 2; n++) @(posedge clk);
        rdc(`UBF_IDX_DBUF, 8'h69);
        apb(1'b1, `UBF_IDX_GCR, 8'h13); apb(1'b1, `UBF_IDX_DBUF, 8'h0F); sck_per(2);
        wrap_up();
    end
endmodule

// ==== verif/ubf_peer.sv ====
// Purpose: far side serial device, frame sender and echoing slave
// Assumes: one stop bit, bit time in system clocks
// Notes: line idles at its pull-up level
`timescale 1ns/1ps
module ubf_peer #(parameter int BIT_CLKS = 16) (
    input  wire logic       clk_i, send_i, bad_stop_i, mosi_i,
    input  wire logic [7:0] byte_i,
    output logic            rxd_o, miso_o
);
    logic [9:0] frame_q = 10'h3FF; // start, data lsb first, stop
    int         left_q  = 0;       // clocks left in the frame
    assign rxd_o  = (left_q == 0) ? 1'b1 : frame_q[(10 * BIT_CLKS - left_q) / BIT_CLKS];
    assign miso_o = ~mosi_i;       // inverted echo
    // load a frame, then count it out
    always @(posedge clk_i) begin
        if (send_i) begin
            frame_q <= {~bad_stop_i, byte_i, 1'b0};
            left_q  <= 10 * BIT_CLKS;
        end else if (left_q != 0) begin
            left_q <= left_q - 1;
        end
    end
endmodule

// ==== verif/ubf_unit_sva.sv ====
// Purpose: port level checks of one serial unit
// Assumes: sees the unit ports only
// Notes: bound to every unit instance
`timescale 1ns/1ps
`include "ubf_regs.vh"
module ubf_unit_sva (
    // every unit port, watched only
    input wire logic        clk_sys_i, rst_n_i, ce_i, psel_i, penable_i, pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i, prdata_o,
    input wire logic        pready_o, pslverr_o, rxd_i, txd_o, sck_o, mosi_o, miso_i,
    input wire logic        rx_irq_o, tx_irq_o, rx_dma_trigger_o, tx_dma_trigger_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire [9:0] idx = paddr_i[11:2];   // word index
    wire       acc = psel_i & penable_i; // access phase
    wire       hit = (idx == `UBF_IDX_CSR) | (idx == `UBF_IDX_UCR) | (idx == `UBF_IDX_DBUF)
                   | (idx == `UBF_IDX_BAUD) | (idx == `UBF_IDX_IRQ) | (idx == `UBF_IDX_GCR);
    property p_ready; acc && ce_i |-> pready_o; endproperty
    a_ready: assert property (p_ready) else $error("no ready in access");
    property p_stall; !ce_i |-> !pready_o; endproperty
    a_stall: assert property (p_stall) else $error("ready while frozen");
    property p_ok; acc && hit |-> !pslverr_o; endproperty
    a_ok: assert property (p_ok) else $error("error on mapped place");
    property p_err; acc && !hit |-> pslverr_o; endproperty
    a_err: assert property (p_err) else $error("no error on hole");
    property p_rx_pulse; $rose(rx_dma_trigger_o) |=> !rx_dma_trigger_o; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx trigger too long");
    property p_tx_pulse; $rose(tx_dma_trigger_o) |=> !tx_dma_trigger_o; endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx trigger too long");
    property p_flush; acc && ce_i && pwrite_i && idx == `UBF_IDX_UCR && pwdata_i[7] |=> txd_o;
    endproperty
    a_flush: assert property (p_flush) else $error("line busy after flush");
    property p_rst; $rose(rst_n_i) |-> txd_o && !sck_o && !rx_irq_o && !tx_irq_o; endproperty
    a_rst: assert property (p_rst) else $error("pins not idle at reset");
endmodule
bind ubf_unit ubf_unit_sva u_ubf_unit_sva (.clk_sys_i, .rst_n_i, .ce_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .rxd_i, .txd_o, .sck_o,
    .mosi_o, .miso_i, .rx_irq_o, .tx_irq_o, .rx_dma_trigger_o, .tx_dma_trigger_o);
